// >>> design/pmst_readback.v
`timescale 1ns/1ps
`default_nettype none
`include "pmst_consts.vh"
module pmst_readback #(
  parameter [6:0] P_ADDR = `PMST_ADDR_DEF,
  parameter [7:0] P_REV  = `PMST_REV_DEF
) (
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_scl,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe,
  output wire        o_alert_out_n,
  output wire        o_alert_out_n_oe,
  input  wire        i_shared_fault_line_1_n,
  input  wire        i_shared_fault_line_0_n,
  input  wire        i_ot_fault,
  input  wire        i_ot_warn,
  input  wire        i_ut_warn,
  input  wire        i_ut_fault,
  input  wire        i_nvm_fault,
  input  wire [7:0]  i_discharge_fault,
  input  wire [7:0]  i_start_attempt,
  input  wire [7:0]  i_line1_shutdown,
  input  wire [7:0]  i_line0_shutdown,
  input  wire [7:0]  i_servo_reached,
  input  wire [7:0]  i_trim_dac_output_on,
  input  wire [7:0]  i_dac_saturated,
  input  wire [7:0]  i_channel_on_cmd,
  input  wire [7:0]  i_off_on_discharge,
  input  wire [7:0]  i_adc_hires,
  input  wire        i_vinen_faulted_off,
  input  wire        i_watchdog_fault,
  input  wire        i_adc_valid,
  input  wire [3:0]  i_adc_src,
  input  wire [15:0] i_adc_l16,
  input  wire [15:0] i_adc_l11,
  output wire [2:0]  o_page,
  output wire        o_clear_faults,
  output wire [7:0]  o_turn_off_req,
  output wire        o_status_word_temp,
  output wire        o_status_word_cml
);
  localparam [2:0] ST_IDLE = 3'd0, ST_BIT = 3'd1, ST_ACK = 3'd2;
  localparam [2:0] ST_TX   = 3'd3, ST_RACK = 3'd4, ST_WAIT = 3'd5;
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer k;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (k = 0; k < 8; k = k + 1) begin
        r = r[7] ? ({r[6:0], 1'b0} ^ `PMST_PEC_POLY) : {r[6:0], 1'b0};
      end
      crc8 = r;
    end
  endfunction
  function known;
    input [7:0] c;
    begin
      case (c)
        `PMST_CMD_PAGE, `PMST_CMD_CLEAR, `PMST_CMD_TEMP, `PMST_CMD_CML,
        `PMST_CMD_MFR, `PMST_CMD_VIN, `PMST_CMD_VOUT, `PMST_CMD_TEMP1,
        `PMST_CMD_REV: known = 1'b1;
        default: known = 1'b0;
      endcase
    end
  endfunction
  wire [3:0] sync_q;
  wire       scl_s = sync_q[0], sda_s = sync_q[1];
  wire       line0_s = sync_q[2], line1_s = sync_q[3];

  pmst_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_d       ({i_shared_fault_line_1_n, i_shared_fault_line_0_n, i_sda, i_scl}),
    .o_q       (sync_q)
  );
  reg [2:0]  state_reg, byte_idx_reg, page_reg;
  reg [3:0]  bit_cnt_reg, temp_reg;
  reg [1:0]  rd_idx_reg;
  reg [4:0]  cml_reg;
  reg [7:0]  sh_reg, tx_reg, cmd_reg, data_reg, crc_reg;
  reg [7:0]  disch_reg, f1_reg, f0_reg, sat_reg, off_reg;
  reg [15:0] rd_word_reg, vin_reg, tmp1_reg;
  reg [15:0] vout_reg [0:7];
  reg        is_read_reg, have_cmd_reg, got_data_reg, pec_bad_reg, mack_reg;
  reg        scl_d_reg, sda_d_reg, sda_oe_reg, clr_reg;
  reg        ev_cmd_reg, ev_data_reg, ev_pec_reg, ev_bus_reg;
  reg        wdog_reg, alert_reg, sw_temp_reg, sw_cml_reg;
  wire scl_rise  = scl_s & ~scl_d_reg, scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  wire [7:0] temp_byte = {temp_reg, 4'h0};
  wire [7:0] cml_byte = {cml_reg[4:1], 2'b00, cml_reg[0], 1'b0};
  wire [7:0] mfr_byte = {disch_reg[page_reg], f1_reg[page_reg], f0_reg[page_reg],
                         i_servo_reached[page_reg], i_trim_dac_output_on[page_reg],
                         sat_reg[page_reg], i_vinen_faulted_off, wdog_reg};

  reg [15:0] cur_word;
  always @* begin
    case (cmd_reg)
      `PMST_CMD_PAGE:  cur_word = {13'h0000, page_reg};
      `PMST_CMD_TEMP:  cur_word = {8'h00, temp_byte};
      `PMST_CMD_CML:   cur_word = {8'h00, cml_byte};
      `PMST_CMD_MFR:   cur_word = {8'h00, mfr_byte};
      `PMST_CMD_VIN:   cur_word = vin_reg;
      `PMST_CMD_VOUT:  cur_word = vout_reg[page_reg];
      `PMST_CMD_TEMP1: cur_word = tmp1_reg;
      `PMST_CMD_REV:   cur_word = {8'h00, P_REV};
      default:         cur_word = {8'h00, `PMST_FILL};
    endcase
  end

  wire       is_word = (cmd_reg == `PMST_CMD_VIN) || (cmd_reg == `PMST_CMD_VOUT) ||
                       (cmd_reg == `PMST_CMD_TEMP1);
  wire [1:0] rd_len = is_word ? 2'd2 : 2'd1;
  reg  [7:0] rd_byte;
  always @* begin
    if (rd_idx_reg < rd_len) begin
      rd_byte = rd_idx_reg[0] ? rd_word_reg[15:8] : rd_word_reg[7:0];
    end else if (rd_idx_reg == rd_len) begin
      rd_byte = crc_reg;
    end else begin
      rd_byte = `PMST_FILL;
    end
  end

  wire [2:0] pec_idx = (cmd_reg == `PMST_CMD_PAGE) ? `PMST_PEC_IDXP : `PMST_PEC_IDX;
  wire tx_load = scl_fall & (((state_reg == ST_ACK) & is_read_reg) |
                             ((state_reg == ST_RACK) & mack_reg));

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      byte_idx_reg <= 3'h0;
      rd_idx_reg   <= 2'h0;
      is_read_reg  <= 1'b0;
      have_cmd_reg <= 1'b0;
      got_data_reg <= 1'b0;
      pec_bad_reg  <= 1'b0;
      mack_reg     <= 1'b0;
      cmd_reg      <= 8'h00;
      data_reg     <= 8'h00;
      crc_reg      <= 8'h00;
      rd_word_reg  <= 16'h0000;
      page_reg     <= 3'h0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      sda_oe_reg   <= 1'b0;
      ev_cmd_reg   <= 1'b0;
      ev_data_reg  <= 1'b0;
      ev_pec_reg   <= 1'b0;
      ev_bus_reg   <= 1'b0;
      clr_reg      <= 1'b0;
    end else begin
      scl_d_reg   <= scl_s;
      sda_d_reg   <= sda_s;
      ev_cmd_reg  <= 1'b0;
      ev_data_reg <= 1'b0;
      ev_pec_reg  <= 1'b0;
      ev_bus_reg  <= 1'b0;
      clr_reg     <= 1'b0;
      if (start_det) begin
        // a repeated start keeps the command and running pec
        state_reg    <= ST_BIT;
        bit_cnt_reg  <= 4'h0;
        byte_idx_reg <= 3'h0;
        sda_oe_reg   <= 1'b0;
      end else if (stop_det) begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        // writes act only at stop, so a bad pec can still veto them
        if (!is_read_reg && have_cmd_reg && !pec_bad_reg) begin
          if (cmd_reg == `PMST_CMD_PAGE && got_data_reg) begin
            if (data_reg > `PMST_PAGE_LIM) begin
              ev_data_reg <= 1'b1;
            end else begin
              page_reg <= data_reg[2:0];
            end
          end
          if (cmd_reg == `PMST_CMD_CLEAR) begin
            clr_reg <= 1'b1;
          end
        end
        have_cmd_reg <= 1'b0;
        is_read_reg  <= 1'b0;
        got_data_reg <= 1'b0;
        pec_bad_reg  <= 1'b0;
      end else if (tx_load) begin
        tx_reg      <= rd_byte;
        crc_reg     <= crc8(crc_reg, rd_byte);
        sda_oe_reg  <= ~rd_byte[7];
        bit_cnt_reg <= 4'h1;
        rd_idx_reg  <= (rd_idx_reg == `PMST_RD_MAX) ? rd_idx_reg : rd_idx_reg + 2'h1;
        state_reg   <= ST_TX;
      end else begin
        case (state_reg)
          ST_BIT: begin
            if (scl_rise) begin
              sh_reg      <= {sh_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `PMST_NBITS) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= ST_ACK;
              sda_oe_reg  <= 1'b1;
              if (byte_idx_reg == 3'h0) begin
                if (sh_reg[7:1] != P_ADDR) begin
                  state_reg  <= ST_WAIT;
                  sda_oe_reg <= 1'b0;
                end else if (!sh_reg[0]) begin
                  crc_reg      <= crc8(8'h00, sh_reg);
                  is_read_reg  <= 1'b0;
                  byte_idx_reg <= 3'h1;
                end else if (have_cmd_reg) begin
                  crc_reg     <= crc8(crc_reg, sh_reg);
                  is_read_reg <= 1'b1;
                  rd_idx_reg  <= 2'h0;
                  rd_word_reg <= cur_word;
                end else begin
                  ev_bus_reg <= 1'b1;
                  state_reg  <= ST_WAIT;
                  sda_oe_reg <= 1'b0;
                end
              end else begin
                crc_reg <= crc8(crc_reg, sh_reg);
                if (byte_idx_reg != `PMST_IDX_MAX) begin
                  byte_idx_reg <= byte_idx_reg + 3'h1;
                end
                if (byte_idx_reg == 3'h1) begin
                  cmd_reg      <= sh_reg;
                  have_cmd_reg <= 1'b1;
                  if (!known(sh_reg)) begin
                    ev_cmd_reg <= 1'b1;
                  end
                end else if (byte_idx_reg == 3'h2 && cmd_reg == `PMST_CMD_PAGE) begin
                  data_reg     <= sh_reg;
                  got_data_reg <= 1'b1;
                end else if (byte_idx_reg != pec_idx || sh_reg != crc_reg) begin
                  ev_pec_reg  <= 1'b1;
                  pec_bad_reg <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_BIT;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `PMST_NBITS) begin
                sda_oe_reg <= 1'b0;
                state_reg  <= ST_RACK;
              end else begin
                tx_reg      <= {tx_reg[6:0], 1'b1};
                sda_oe_reg  <= ~tx_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s;
            end else if (scl_fall) begin
              state_reg <= ST_WAIT;
            end
          end
          ST_IDLE, ST_WAIT: begin
            sda_oe_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // status flags: a set in the clearing cycle wins
  wire [7:0] ch_clr = {8{clr_reg}} | i_channel_on_cmd;
  wire [3:0] temp_next = (clr_reg ? 4'h0 : temp_reg) |
                         {i_ot_fault, i_ot_warn, i_ut_warn, i_ut_fault};
  wire [4:0] cml_next = (clr_reg ? 5'h00 : cml_reg) |
                        {ev_cmd_reg, ev_data_reg, ev_pec_reg, i_nvm_fault, ev_bus_reg};
  wire [7:0] disch_next = (disch_reg & ~ch_clr) | i_discharge_fault;
  wire [7:0] f1_next = (f1_reg & ~ch_clr) | i_line1_shutdown | (i_start_attempt & {8{~line1_s}});
  wire [7:0] f0_next = (f0_reg & ~ch_clr) | i_line0_shutdown | (i_start_attempt & {8{~line0_s}});
  wire [7:0] sat_next = (sat_reg & ~ch_clr) | i_dac_saturated;
  wire       wdog_next = (wdog_reg & ~clr_reg) | i_watchdog_fault;
  // dac saturation is sticky but deliberately left off the alert
  wire alert_next = (|disch_next) | (|f1_next) | (|f0_next) | wdog_next;
  integer i;

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      temp_reg    <= 4'h0;
      cml_reg     <= 5'h00;
      disch_reg   <= 8'h00;
      f1_reg      <= 8'h00;
      f0_reg      <= 8'h00;
      sat_reg     <= 8'h00;
      wdog_reg    <= 1'b0;
      alert_reg   <= 1'b0;
      sw_temp_reg <= 1'b0;
      sw_cml_reg  <= 1'b0;
      off_reg     <= 8'h00;
    end else begin
      temp_reg    <= temp_next;
      cml_reg     <= cml_next;
      disch_reg   <= disch_next;
      f1_reg      <= f1_next;
      f0_reg      <= f0_next;
      sat_reg     <= sat_next;
      wdog_reg    <= wdog_next;
      alert_reg   <= alert_next;
      sw_temp_reg <= |temp_next;
      sw_cml_reg  <= |cml_next;
      off_reg     <= i_discharge_fault & i_off_on_discharge;
    end
  end

  // whole words latch per conversion; reads also snapshot at address
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vin_reg  <= 16'h0000;
      tmp1_reg <= 16'h0000;
      for (i = 0; i < 8; i = i + 1) begin
        vout_reg[i] <= 16'h0000;
      end
    end else if (i_adc_valid) begin
      if (i_adc_src == `PMST_SRC_VIN) begin
        vin_reg <= i_adc_l11;
      end else if (i_adc_src == `PMST_SRC_TEMP) begin
        tmp1_reg <= i_adc_l11;
      end else if (!i_adc_src[3]) begin
        vout_reg[i_adc_src[2:0]] <= (i_adc_src[0] && i_adc_hires[i_adc_src[2:0]]) ?
                                    i_adc_l11 : i_adc_l16;
      end
    end
  end

  assign o_sda              = 1'b0;
  assign o_sda_oe           = sda_oe_reg;
  assign o_alert_out_n      = 1'b0;
  assign o_alert_out_n_oe   = alert_reg;
  assign o_page             = page_reg;
  assign o_clear_faults     = clr_reg;
  assign o_turn_off_req     = off_reg;
  assign o_status_word_temp = sw_temp_reg;
  assign o_status_word_cml  = sw_cml_reg;
endmodule
`default_nettype wire

// >>> design/pmst_consts.vh
`ifndef PMST_CONSTS_VH
`define PMST_CONSTS_VH
// arbitrary bus address and revision value
`define PMST_ADDR_DEF  7'h5c
`define PMST_REV_DEF   8'h22
`define PMST_CMD_PAGE  8'h00
`define PMST_CMD_CLEAR 8'h03
`define PMST_CMD_TEMP  8'h7d
`define PMST_CMD_CML   8'h7e
`define PMST_CMD_MFR   8'h80
`define PMST_CMD_VIN   8'h88
`define PMST_CMD_VOUT  8'h8b
`define PMST_CMD_TEMP1 8'h8d
`define PMST_CMD_REV   8'h98
`define PMST_CML_CMD   7
`define PMST_CML_DATA  6
`define PMST_CML_PEC   5
`define PMST_CML_MEM   4
`define PMST_CML_BUS   1
`define PMST_PEC_POLY  8'h07
`define PMST_PAGE_LIM  8'h07
`define PMST_SRC_VIN   4'h8
`define PMST_SRC_TEMP  4'h9
`define PMST_NBITS     4'h8
`define PMST_FILL      8'hff
`define PMST_PEC_IDX   3'h2
`define PMST_PEC_IDXP  3'h3
`define PMST_IDX_MAX   3'h7
`define PMST_RD_MAX    2'h3
`endif

// >>> design/pmst_sync.v
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for pin inputs
module pmst_sync (
  input  wire       i_sys_clk,
  input  wire       i_rstn,
  input  wire [3:0] i_d,
  output wire [3:0] o_q
);
  reg [3:0] meta_reg;
  reg [3:0] q_reg;
  // idle bus and fault lines sit high, so reset to high
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= 4'hf;
      q_reg    <= 4'hf;
    end else begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end
  assign o_q = q_reg;
endmodule
`default_nettype wire

// >>> verification/pmst_readback_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmst_readback_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_rstn,
  input wire logic       i_ot_fault,
  input wire logic       i_nvm_fault,
  input wire logic       i_watchdog_fault,
  input wire logic [7:0] i_discharge_fault,
  input wire logic [7:0] i_off_on_discharge,
  input wire logic [7:0] i_start_attempt,
  input wire logic [7:0] i_line1_shutdown,
  input wire logic [7:0] i_line0_shutdown,
  input wire logic       o_alert_out_n_oe,
  input wire logic       o_clear_faults,
  input wire logic [7:0] o_turn_off_req,
  input wire logic       o_status_word_temp,
  input wire logic       o_status_word_cml
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  wire logic [7:0] cause = i_discharge_fault & i_off_on_discharge;
  // a set racing the clear wins, so only quiet clears are judged
  wire logic quiet = ~|{i_discharge_fault, i_start_attempt, i_line1_shutdown,
                        i_line0_shutdown, i_watchdog_fault};
  sequence s_wdog_edge;
    !i_watchdog_fault ##1 i_watchdog_fault;
  endsequence
  sequence s_quiet_clear;
    o_clear_faults && quiet ##1 quiet [*3];
  endsequence
  chk_wdog_alert: assert property (s_wdog_edge |-> ##[1:3] o_alert_out_n_oe)
    else $error("no alert after watchdog");
  chk_disch_alert: assert property (
    $rose(|i_discharge_fault) |-> ##[1:3] o_alert_out_n_oe) else $error("no alert after discharge");
  chk_clear_alert: assert property (s_quiet_clear |-> !o_alert_out_n_oe)
    else $error("alert held after clear");
  chk_turn_off_set: assert property (
    cause != 8'h00 |=> (o_turn_off_req & $past(cause)) == $past(cause)) else $error("no turn-off");
  chk_turn_off_none: assert property (cause == 8'h00 |=> o_turn_off_req == 8'h00)
    else $error("turn-off without cause");
  chk_temp_summary: assert property ($rose(i_ot_fault) |-> ##[1:2] o_status_word_temp)
    else $error("summary temp bit missing");
  chk_temp_held: assert property (o_status_word_temp |=> o_status_word_temp || o_clear_faults
    || $past(o_clear_faults) || $past(o_clear_faults, 2)) else $error("summary temp bit lost");
  chk_cml_memory: assert property ($rose(i_nvm_fault) |-> ##[1:3] o_status_word_cml)
    else $error("summary comm bit missing");
endmodule
bind pmst_readback pmst_readback_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_ot_fault(i_ot_fault), .i_nvm_fault(i_nvm_fault), .i_watchdog_fault(i_watchdog_fault),
  .i_discharge_fault(i_discharge_fault), .i_off_on_discharge(i_off_on_discharge),
  .i_start_attempt(i_start_attempt), .i_line1_shutdown(i_line1_shutdown),
  .i_line0_shutdown(i_line0_shutdown), .o_alert_out_n_oe(o_alert_out_n_oe),
  .o_clear_faults(o_clear_faults), .o_turn_off_req(o_turn_off_req),
  .o_status_word_temp(o_status_word_temp), .o_status_word_cml(o_status_word_cml));
`default_nettype wire

// >>> verification/pmst_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus host: clock idles high outside frames, data released to the pull-up
module pmst_host_model (
  output var logic o_scl,
  output var logic o_sda_rel,
  input  wire logic i_sda
);
  localparam realtime Q = 31.25;
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
  end
  task automatic put(input logic b);
    #Q o_sda_rel = b;
    #Q o_scl = 1'b1;
    #(2 * Q) o_scl = 1'b0;
  endtask
  task automatic get(output logic b);
    #Q o_sda_rel = 1'b1;
    #Q o_scl = 1'b1;
    #Q b = i_sda;
    #Q o_scl = 1'b0;
  endtask
  // also serves as the repeated start
  task automatic start();
    #Q o_sda_rel = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_rel = 1'b0;
    #Q o_scl = 1'b0;
  endtask
  task automatic stop();
    #Q o_sda_rel = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_rel = 1'b1;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(n);
    ack = ~n;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_pmbus_status_telemetry_readback.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmst_consts.vh"
module tb_pmbus_status_telemetry_readback;
  localparam logic [6:0] ADDR = `PMST_ADDR_DEF;
  localparam logic [7:0] REV  = 8'h3a; // arbitrary value
  logic        clk = 1'b0, rstn = 1'b0, f1_n = 1'b1, f0_n = 1'b1;
  logic        nvm = 1'b0, vinen = 1'b0, wdog = 1'b0, adc_v = 1'b0;
  logic [3:0]  tmp = 4'h0, src = 4'h0;
  logic [7:0]  disch = 8'h00, strt = 8'h00, sh1 = 8'h00, sh0 = 8'h00, servo = 8'h00;
  logic [7:0]  dacon = 8'h00, sat = 8'h00, on_cmd = 8'h00, off_cfg = 8'h00, hires = 8'h08;
  logic [15:0] l16 = 16'h0000, l11 = 16'h0000;
  wire         scl, rel, sda_o, sda_oe, al_n, al_oe, clr, tsum, csum;
  wire  [2:0]  page;
  wire  [7:0]  toff;
  wire         sda = rel & ~(sda_oe & ~sda_o);
  int          failures = 0, checked = 0;
  always #5 clk = ~clk;
  pmst_host_model host (.o_scl(scl), .o_sda_rel(rel), .i_sda(sda));
  pmst_readback #(.P_ADDR(ADDR), .P_REV(REV)) dut (.i_sys_clk(clk), .i_rstn(rstn),
    .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_alert_out_n(al_n),
    .o_alert_out_n_oe(al_oe), .i_shared_fault_line_1_n(f1_n), .i_shared_fault_line_0_n(f0_n),
    .i_ot_fault(tmp[3]), .i_ot_warn(tmp[2]), .i_ut_warn(tmp[1]), .i_ut_fault(tmp[0]),
    .i_nvm_fault(nvm), .i_discharge_fault(disch), .i_start_attempt(strt),
    .i_line1_shutdown(sh1), .i_line0_shutdown(sh0), .i_servo_reached(servo),
    .i_trim_dac_output_on(dacon), .i_dac_saturated(sat), .i_channel_on_cmd(on_cmd),
    .i_off_on_discharge(off_cfg), .i_adc_hires(hires), .i_vinen_faulted_off(vinen),
    .i_watchdog_fault(wdog), .i_adc_valid(adc_v), .i_adc_src(src), .i_adc_l16(l16),
    .i_adc_l11(l11), .o_page(page), .o_clear_faults(clr), .o_turn_off_req(toff),
    .o_status_word_temp(tsum), .o_status_word_cml(csum));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ `PMST_PEC_POLY : {r[6:0], 1'b0};
    return r;
  endfunction
  task automatic send(input logic [7:0] d, inout logic [7:0] p);
    logic a;
    host.wbyte(d, a);
    p = crc(p, d);
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
    logic [7:0] p, b;
    p = 8'h00;
    v = 16'h0000;
    host.start();
    send({ADDR, 1'b0}, p);
    send(cmd, p);
    host.start();
    send({ADDR, 1'b1}, p);
    for (int i = 0; i < n; i++) begin
      host.rbyte(1'b0, b);
      p = crc(p, b);
      v[8*i +: 8] = b;
    end
    host.rbyte(1'b1, b);
    host.stop();
    check(b, p);
  endtask
  task automatic rchk(input logic [7:0] cmd, input int n, input logic [15:0] e);
    logic [15:0] v;
    rd(cmd, n, v);
    check(v, e);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic dat,
                    input logic [7:0] bad);
    logic [7:0] p;
    p = 8'h00;
    host.start();
    send({ADDR, 1'b0}, p);
    send(cmd, p);
    if (dat) send(d, p);
    send(p ^ bad, p);
    host.stop();
    repeat (6) @(posedge clk);
  endtask
  task automatic clear();
    wr(`PMST_CMD_CLEAR, 8'h00, 1'b0, 8'h00);
  endtask
  task automatic page_to(input logic [7:0] pg);
    wr(`PMST_CMD_PAGE, pg, 1'b1, 8'h00);
  endtask
  task automatic s_temp();
    logic [3:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 4'h1 << k;
      @(posedge clk) tmp <= m;
      @(posedge clk) tmp <= 4'h0;
      repeat (3) @(posedge clk);
      check(tsum, 1'b1);
      rchk(`PMST_CMD_TEMP, 1, {8'h00, m, 4'h0});
      clear();
      check(tsum, 1'b0);
    end
  endtask
  task automatic s_cml();
    logic a;
    rchk(8'hc7, 1, {8'h00, `PMST_FILL});
    rchk(`PMST_CMD_CML, 1, 16'h0080);
    clear();
    page_to(8'h0d);
    check(page, 3'h0);
    rchk(`PMST_CMD_CML, 1, 16'h0040);
    clear();
    wr(`PMST_CMD_PAGE, 8'h03, 1'b1, 8'h5a);
    check(page, 3'h0);
    rchk(`PMST_CMD_CML, 1, 16'h0020);
    clear();
    @(posedge clk) nvm <= 1'b1;
    @(posedge clk) nvm <= 1'b0;
    rchk(`PMST_CMD_CML, 1, 16'h0010);
    clear();
    host.start();
    host.wbyte({ADDR, 1'b1}, a);
    host.stop();
    check(a, 1'b0);
    rchk(`PMST_CMD_CML, 1, 16'h0002);
    clear();
    rchk(`PMST_CMD_CML, 1, 16'h0000);
  endtask
  task automatic s_mfr();
    page_to(8'h03);
    f1_n <= 1'b0;
    servo <= 8'h08;
    dacon <= 8'h08;
    vinen <= 1'b1;
    off_cfg <= 8'h08;
    repeat (4) @(posedge clk);
    {disch, strt, sh0, sat, wdog} <= {8'h08, 8'h08, 8'h08, 8'h08, 1'b1};
    @(posedge clk) {disch, strt, sh0, sat, wdog} <= 33'h0;
    repeat (4) @(posedge clk);
    check({al_oe, al_n}, 2'b10);
    rchk(`PMST_CMD_MFR, 1, 16'h00ff);
    @(posedge clk) f1_n <= 1'b1;
    page_to(8'h02);
    rchk(`PMST_CMD_MFR, 1, 16'h0003);
    page_to(8'h03);
    @(posedge clk) on_cmd <= 8'h08;
    @(posedge clk) on_cmd <= 8'h00;
    rchk(`PMST_CMD_MFR, 1, 16'h001b);
    clear();
    check(al_oe, 1'b0);
    rchk(`PMST_CMD_MFR, 1, 16'h001a);
    @(posedge clk) sat <= 8'h08;
    @(posedge clk) sat <= 8'h00;
    repeat (4) @(posedge clk);
    check(al_oe, 1'b0);
    rchk(`PMST_CMD_MFR, 1, 16'h001e);
    clear();
    servo <= 8'h00;
    vinen <= 1'b0;
    rchk(`PMST_CMD_MFR, 1, 16'h0008);
  endtask
  task automatic conv(input logic [3:0] s, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk) {adc_v, src, l16, l11} <= {1'b1, s, a, b};
    @(posedge clk) {adc_v, l16, l11} <= {1'b0, ~a, ~b};
  endtask
  task automatic s_adc();
    conv(4'h3, 16'h1234, 16'hd2a5);
    conv(4'h2, 16'h0456, 16'hbeef);
    conv(`PMST_SRC_VIN, 16'h1111, 16'hcafe);
    conv(`PMST_SRC_TEMP, 16'h2222, 16'h1bad);
    conv(4'hc, 16'h5555, 16'h6666);
    rchk(`PMST_CMD_VOUT, 2, 16'hd2a5);
    page_to(8'h02);
    rchk(`PMST_CMD_VOUT, 2, 16'h0456);
    rchk(`PMST_CMD_VIN, 2, 16'hcafe);
    rchk(`PMST_CMD_TEMP1, 2, 16'h1bad);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rchk(`PMST_CMD_REV, 1, {8'h00, REV});
    s_temp();
    s_cml();
    s_mfr();
    s_adc();
    report_and_stop();
  end
  initial begin
    #900000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
